// [src/frame_timing_map.vh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-addressed register port, byte offsets as printed
// Notes: Definitions only
`ifndef FRAME_TIMING_MAP_VH
`define FRAME_TIMING_MAP_VH
`define OFS_BULK_CUR 8'h2C
`define OFS_DONE_HEAD 8'h30
`define OFS_FM_INTERVAL 8'h34
`define OFS_FM_REMAIN 8'h38
`define OFS_FM_NUMBER 8'h3C
`define OFS_PERIODIC_START 8'h40
`define PTR_MSB 31
`define PTR_LSB 4
`define TOGGLE_BIT 31
`define LPB_MSB 30
`define LPB_LSB 16
`define FI_MSB 13
`define FN_MSB 15
`define FI_RESET 14'h2EDF
`define BIT_TIME_NS 83
`define CLK_PERIOD_NS 100
`define BIT_TIME_CYCLES 1
`endif

// [src/frame_downcounter.v]
// Purpose: Frame-remaining down counter with reload and toggle copy
// Assumes: One bit time per tick input
// Notes: Zero pulse marks a frame boundary
`timescale 1ns/1ns
`default_nettype none
module frame_downcounter #(
  parameter W = 14
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire tick_in,
  input wire reload_in,
  input wire [W-1:0] interval_in,
  input wire toggle_in,
  input wire wr_in,
  input wire [W-1:0] wr_value_in,
  input wire wr_toggle_in,
  output reg [W-1:0] count_out,
  output reg toggle_out,
  output reg boundary_out
);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= {W{1'b0}};
      toggle_out <= 1'b0;
      boundary_out <= 1'b0;
    end else begin
      boundary_out <= 1'b0;
      if (reload_in) begin
        count_out <= interval_in;
      end else if (wr_in) begin
        count_out <= wr_value_in;
        toggle_out <= wr_toggle_in;
      end else if (tick_in) begin
        if (count_out == {W{1'b0}}) begin
          count_out <= interval_in;
          toggle_out <= toggle_in;
          boundary_out <= 1'b1;
        end else begin
          count_out <= count_out - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // frame_downcounter
`default_nettype wire

// [src/frame_timing_list_ptrs.v]
// Purpose: Frame timing and bulk/done list pointers of a host controller core
// Assumes: Register port with address, write and read strobes on the core clock
// Notes: Engine events arrive as one-cycle pulses from same-clock logic
//
// How it works
// - Bulk list served round-robin; pointer advances to next endpoint after service.
// - At bulk list end, if list-filled set copy head and clear flag.
// - Bulk current pointer resets to zero, meaning end of list.
// - Completed descriptor gets old done head, then done head takes its address.
// - Done head clears to zero when written to shared area.
// - Frame interval is 14 bits, resets to 11,999.
// - Largest-packet field loads a counter at every frame start.
// - Frame remaining decrements per bit time, reloads from interval at zero.
// - At zero, interval toggle is copied into remaining toggle.
// - Entering operational state reloads remaining from interval.
// - Frame number increments on each reload and wraps after FFFFH.
// - Frame number increments on entering operational state.
// - Frame number written to shared area after start of frame, before endpoints.
// - Start-of-frame flag set once that write completes.
// - Periodic start clears on hardware reset; earliest remaining value for periodic.
// - At periodic start, periodic lists win after current transaction finishes.
`timescale 1ns/1ns
`default_nettype none
`include "frame_timing_map.vh"
module frame_timing_list_ptrs #(
  parameter FI_W = 14,
  parameter LPB_W = 15
) (
  input wire CORE_CLK_IN,
  input wire RST_N_IN,
  input wire [7:0] REG_ADDR_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [31:0] REG_WDATA_IN,
  input wire BIT_TICK_IN,
  input wire OPERATIONAL_ENTER_IN,
  input wire BULK_LIST_ENABLE_IN,
  input wire LIST_FILLED_FLAG_IN,
  input wire [31:0] BULK_HEAD_IN,
  input wire BULK_SERVED_IN,
  input wire [31:0] BULK_NEXT_IN,
  input wire TD_DONE_IN,
  input wire [31:0] TD_ADDR_IN,
  input wire DONE_HEAD_WB_IN,
  input wire SOF_SENT_IN,
  input wire MEM_WR_DONE_IN,
  input wire XFER_BUSY_IN,
  output reg [31:0] REG_RDATA_OUT,
  output reg LIST_FILLED_CLEAR_OUT,
  output reg [31:0] TD_NEXT_OUT,
  output reg TD_NEXT_WR_OUT,
  output reg [31:0] SHARED_FN_OUT,
  output reg SHARED_FN_WR_OUT,
  output reg START_OF_FRAME_FLAG_OUT,
  output reg [LPB_W-1:0] LARGEST_PACKET_COUNT_OUT,
  output reg PERIODIC_PRIORITY_OUT
);
  reg [27:0] bulk_current_pointer_q;
  reg [27:0] done_queue_head_q;
  reg [FI_W-1:0] frame_interval_q;
  reg [LPB_W-1:0] largest_packet_bits_q;
  reg interval_toggle_q;
  reg [`FN_MSB:0] frame_number_q;
  reg [FI_W-1:0] periodic_start_q;
  reg fn_pending_q;
  reg periodic_due_q;
  wire [FI_W-1:0] frame_remaining;
  wire remaining_toggle;
  wire boundary;
  wire wr_remain;
  reg [31:0] rdata_d;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign wr_remain = REG_WR_IN && hit(REG_ADDR_IN, `OFS_FM_REMAIN);

  frame_downcounter #(
    .W(FI_W)
  ) u_remain (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_in(BIT_TICK_IN),
    .reload_in(OPERATIONAL_ENTER_IN),
    .interval_in(frame_interval_q),
    .toggle_in(interval_toggle_q),
    .wr_in(wr_remain),
    .wr_value_in(REG_WDATA_IN[FI_W-1:0]),
    .wr_toggle_in(REG_WDATA_IN[`TOGGLE_BIT]),
    .count_out(frame_remaining),
    .toggle_out(remaining_toggle),
    .boundary_out(boundary)
  );

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bulk_current_pointer_q <= 28'h000_0000;
      done_queue_head_q <= 28'h000_0000;
      frame_interval_q <= `FI_RESET;
      largest_packet_bits_q <= 15'h0000;
      interval_toggle_q <= 1'b0;
      frame_number_q <= 16'h0000;
      periodic_start_q <= 14'h0000;
      fn_pending_q <= 1'b0;
      periodic_due_q <= 1'b0;
      LIST_FILLED_CLEAR_OUT <= 1'b0;
      TD_NEXT_OUT <= 32'h0000_0000;
      TD_NEXT_WR_OUT <= 1'b0;
      SHARED_FN_OUT <= 32'h0000_0000;
      SHARED_FN_WR_OUT <= 1'b0;
      START_OF_FRAME_FLAG_OUT <= 1'b0;
      LARGEST_PACKET_COUNT_OUT <= 15'h0000;
      PERIODIC_PRIORITY_OUT <= 1'b0;
      REG_RDATA_OUT <= 32'h0000_0000;
    end else begin
      LIST_FILLED_CLEAR_OUT <= 1'b0;
      TD_NEXT_WR_OUT <= 1'b0;
      SHARED_FN_WR_OUT <= 1'b0;
      START_OF_FRAME_FLAG_OUT <= 1'b0;

      if (BULK_SERVED_IN && BULK_NEXT_IN[`PTR_MSB:`PTR_LSB] != 28'h000_0000) begin
        bulk_current_pointer_q <= BULK_NEXT_IN[`PTR_MSB:`PTR_LSB];
      end else if (BULK_SERVED_IN) begin
        if (LIST_FILLED_FLAG_IN) begin
          bulk_current_pointer_q <= BULK_HEAD_IN[`PTR_MSB:`PTR_LSB];
          LIST_FILLED_CLEAR_OUT <= 1'b1;
        end else begin
          bulk_current_pointer_q <= 28'h000_0000;
        end
      end else if (REG_WR_IN && hit(REG_ADDR_IN, `OFS_BULK_CUR) && !BULK_LIST_ENABLE_IN) begin
        bulk_current_pointer_q <= REG_WDATA_IN[`PTR_MSB:`PTR_LSB];
      end

      if (TD_DONE_IN) begin
        TD_NEXT_OUT <= {done_queue_head_q, 4'h0};
        TD_NEXT_WR_OUT <= 1'b1;
        done_queue_head_q <= TD_ADDR_IN[`PTR_MSB:`PTR_LSB];
      end else if (DONE_HEAD_WB_IN) begin
        done_queue_head_q <= 28'h000_0000;
      end else if (REG_WR_IN && hit(REG_ADDR_IN, `OFS_DONE_HEAD)) begin
        done_queue_head_q <= REG_WDATA_IN[`PTR_MSB:`PTR_LSB];
      end

      if (REG_WR_IN && hit(REG_ADDR_IN, `OFS_FM_INTERVAL)) begin
        frame_interval_q <= REG_WDATA_IN[FI_W-1:0];
        largest_packet_bits_q <= REG_WDATA_IN[`LPB_MSB:`LPB_LSB];
        interval_toggle_q <= REG_WDATA_IN[`TOGGLE_BIT];
      end
      if (REG_WR_IN && hit(REG_ADDR_IN, `OFS_PERIODIC_START)) begin
        periodic_start_q <= REG_WDATA_IN[FI_W-1:0];
      end

      if (boundary || OPERATIONAL_ENTER_IN) begin
        frame_number_q <= frame_number_q + 16'h0001;
        LARGEST_PACKET_COUNT_OUT <= largest_packet_bits_q;
        periodic_due_q <= 1'b0;
        PERIODIC_PRIORITY_OUT <= 1'b0;
      end else begin
        if (REG_WR_IN && hit(REG_ADDR_IN, `OFS_FM_NUMBER)) begin
          frame_number_q <= REG_WDATA_IN[`FN_MSB:0];
        end
        if (frame_remaining == periodic_start_q && BIT_TICK_IN) begin
          periodic_due_q <= 1'b1;
        end
        if ((periodic_due_q || frame_remaining == periodic_start_q) && !XFER_BUSY_IN) begin
          PERIODIC_PRIORITY_OUT <= periodic_due_q;
        end
      end

      if (SOF_SENT_IN) begin
        SHARED_FN_OUT <= {16'h0000, frame_number_q};
        SHARED_FN_WR_OUT <= 1'b1;
        fn_pending_q <= 1'b1;
      end else if (fn_pending_q && MEM_WR_DONE_IN) begin
        START_OF_FRAME_FLAG_OUT <= 1'b1;
        fn_pending_q <= 1'b0;
      end

      REG_RDATA_OUT <= rdata_d;
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `OFS_BULK_CUR: rdata_d = {bulk_current_pointer_q, 4'h0};
        `OFS_DONE_HEAD: rdata_d = {done_queue_head_q, 4'h0};
        `OFS_FM_INTERVAL: rdata_d = {interval_toggle_q, largest_packet_bits_q, 2'b00, frame_interval_q};
        `OFS_FM_REMAIN: rdata_d = {remaining_toggle, 17'h0_0000, frame_remaining};
        `OFS_FM_NUMBER: rdata_d = {18'h0_0000, frame_number_q[FI_W-1:0]};
        `OFS_PERIODIC_START: rdata_d = {18'h0_0000, periodic_start_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
endmodule // frame_timing_list_ptrs
`default_nettype wire

// [tb/frame_timing_list_ptrs_assertions.sv]
// Purpose: Port checks for the frame timing block
// Assumes: One clock, async low reset
// Notes: Bound to the top module
`timescale 1ns/1ns
`default_nettype none
module ftl_checker (
  input wire logic CORE_CLK_IN, RST_N_IN, REG_RD_IN, TD_DONE_IN, SOF_SENT_IN, MEM_WR_DONE_IN,
  input wire logic XFER_BUSY_IN, LIST_FILLED_FLAG_IN, LIST_FILLED_CLEAR_OUT, TD_NEXT_WR_OUT,
  input wire logic SHARED_FN_WR_OUT, START_OF_FRAME_FLAG_OUT, PERIODIC_PRIORITY_OUT,
  input wire logic [31:0] TD_ADDR_IN, TD_NEXT_OUT, REG_RDATA_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  td_write_a: assert property (TD_DONE_IN |=> TD_NEXT_WR_OUT)
    else $error("next pointer not written");
  td_chain_a: assert property (TD_DONE_IN ##1 TD_DONE_IN |=> TD_NEXT_OUT == $past(TD_ADDR_IN, 2))
    else $error("done head chain wrong");
  fn_post_a: assert property (SOF_SENT_IN |=> SHARED_FN_WR_OUT ##1 !SHARED_FN_WR_OUT)
    else $error("frame number write missing");
  flag_set_a: assert property (MEM_WR_DONE_IN |=> START_OF_FRAME_FLAG_OUT)
    else $error("frame flag not set");
  flag_cause_a: assert property (START_OF_FRAME_FLAG_OUT |-> $past(MEM_WR_DONE_IN))
    else $error("frame flag without write");
  clear_idle_a: assert property (!LIST_FILLED_FLAG_IN && !$past(LIST_FILLED_FLAG_IN) |-> !LIST_FILLED_CLEAR_OUT)
    else $error("filled clear without flag");
  prio_rise_a: assert property ($rose(PERIODIC_PRIORITY_OUT) |-> !$past(XFER_BUSY_IN))
    else $error("priority during transfer");
  rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == '0)
    else $error("read data without read");
endmodule // ftl_checker
bind frame_timing_list_ptrs ftl_checker chk_i (.CORE_CLK_IN, .RST_N_IN, .REG_RD_IN, .TD_DONE_IN, .SOF_SENT_IN,
  .MEM_WR_DONE_IN, .XFER_BUSY_IN, .LIST_FILLED_FLAG_IN, .LIST_FILLED_CLEAR_OUT, .TD_NEXT_WR_OUT,
  .SHARED_FN_WR_OUT, .START_OF_FRAME_FLAG_OUT, .PERIODIC_PRIORITY_OUT, .TD_ADDR_IN, .TD_NEXT_OUT, .REG_RDATA_OUT);
`default_nettype wire

// [tb/shared_mem_model.sv]
// Purpose: Shared memory answering frame number writes
// Assumes: Write request is a one-cycle pulse
// Notes: Slow mode answers after four cycles
`timescale 1ns/1ns
`default_nettype none
module shared_mem_model (
  input wire logic clk_in, rst_n_in, wr_in, slow_in,
  output logic done_out
);
  logic [2:0] wait_q;
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 3'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (wait_q == 3'h1);
      if (wr_in) wait_q <= slow_in ? 3'h4 : 3'h1;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    end
  end
endmodule // shared_mem_model
`default_nettype wire

// [tb/frame_timing_list_ptrs_tb_top.sv]
// Purpose: Self-checking bench for the frame timing block
// Assumes: Inputs change on the falling edge
// Notes: Six bit-time frames keep runs short
`timescale 1ns/1ns
`default_nettype none
module frame_timing_list_ptrs_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, tk = 0, op = 0, en = 0, fl = 0, bs = 0, td = 0, wb = 0, ss = 0, slow = 0;
  logic busy = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, bh = 0, bn = 0, ta = 0;
  wire logic [31:0] q, tn, sf;
  wire logic [14:0] lp;
  wire logic fc, tw, sw, md, sof, pp;
  int fail_count = 0, total_checks = 0, cyc = 0;
  logic [39:0] rows [7] = '{{8'h2C, 32'h0}, {8'h30, 32'h0}, {8'h34, 32'h2EDF}, {8'h38, 32'h0},
    {8'h3C, 32'h0}, {8'h40, 32'h0}, {8'h44, 32'h0}};
  frame_timing_list_ptrs dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(adr), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_WDATA_IN(wd), .BIT_TICK_IN(tk), .OPERATIONAL_ENTER_IN(op), .BULK_LIST_ENABLE_IN(en),
    .LIST_FILLED_FLAG_IN(fl), .BULK_HEAD_IN(bh), .BULK_SERVED_IN(bs), .BULK_NEXT_IN(bn), .TD_DONE_IN(td),
    .TD_ADDR_IN(ta), .DONE_HEAD_WB_IN(wb), .SOF_SENT_IN(ss), .MEM_WR_DONE_IN(md), .XFER_BUSY_IN(busy),
    .REG_RDATA_OUT(q), .LIST_FILLED_CLEAR_OUT(fc), .TD_NEXT_OUT(tn), .TD_NEXT_WR_OUT(tw), .SHARED_FN_OUT(sf),
    .SHARED_FN_WR_OUT(sw), .START_OF_FRAME_FLAG_OUT(sof), .LARGEST_PACKET_COUNT_OUT(lp),
    .PERIODIC_PRIORITY_OUT(pp));
  shared_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .wr_in(sw), .slow_in(slow), .done_out(md));
  initial forever #50 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic pl(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
  endtask
  task automatic wrt(logic [7:0] a, logic [31:0] d);
    adr = a;
    wd = d;
    pl(wr);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    adr = a;
    pl(rd);
    chk($sformatf("reg %h", a), e, q);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    foreach (rows[i]) rdc(rows[i][39:32], rows[i][31:0]);
    wrt(8'h40, 32'hFFFF_3E67);
    rdc(8'h40, 32'h3E67);
    $display("test registers end");
    ta = 32'hA10;
    @(negedge clk) td = 1;
    @(negedge clk) ta = 32'hB20;
    @(negedge clk) td = 0;
    chk("td_next", 32'hA10, tn);
    chk("td_next_wr", 1, tw);
    rdc(8'h30, 32'hB20);
    pl(wb);
    rdc(8'h30, 32'h0);
    $display("test done queue end");
    en = 1;
    bn = 32'h100;
    pl(bs);
    rdc(8'h2C, 32'h100);
    fl = 1;
    bh = 32'h200;
    bn = 0;
    pl(bs);
    chk("filled_clear", 1, fc);
    rdc(8'h2C, 32'h200);
    fl = 0;
    wrt(8'h2C, 32'h300);
    rdc(8'h2C, 32'h200);
    chk("filled_clear", 0, fc);
    en = 0;
    wrt(8'h2C, 32'h1234_567F);
    rdc(8'h2C, 32'h1234_5670);
    $display("test bulk list end");
    wrt(8'h34, 32'h8003_0005);
    wrt(8'h40, 32'h2);
    pl(op);
    rdc(8'h38, 32'h5);
    rdc(8'h3C, 32'h1);
    repeat (4) pl(tk);
    @(negedge clk);
    chk("prio", 1, pp);
    repeat (2) pl(tk);
    @(negedge clk);
    rdc(8'h38, 32'h8000_0005);
    rdc(8'h3C, 32'h2);
    chk("lpc", 3, lp);
    chk("prio", 0, pp);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      pl(ss);
      repeat (8) if (sof !== 1'b1) @(negedge clk);
      chk("sof", 1, sof);
      chk("fn", 2, sf[15:0]);
    end
    wrt(8'h34, 32'h0003_0004);
    busy = 1;
    repeat (4) pl(tk);
    @(negedge clk);
    chk("prio_busy", 0, pp);
    busy = 0;
    @(negedge clk);
    chk("prio_free", 1, pp);
    repeat (2) pl(tk);
    @(negedge clk);
    rdc(8'h38, 32'h0000_0004);
    rdc(8'h3C, 32'h3);
    wrt(8'h3C, 32'h0000_FFFF);
    rdc(8'h3C, 32'h3FFF);
    pl(op);
    rdc(8'h3C, 32'h0);
    $display("test frame end");
    rst_n = 0;
    @(negedge clk) rst_n = 1;
    rdc(8'h34, 32'h2EDF);
    wrt(8'h34, 32'h8003_0005);
    rdc(8'h34, 32'h8003_0005);
    rdc(8'h2C, 32'h0);
    $display("test reset end");
    report_and_stop();
  end
endmodule // frame_timing_list_ptrs_tb_top
`default_nettype wire
